/* File: src/rsc_pkg.sv */
// Package for the remote setpoint conditioning block
package rsc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_RANGE_LO = 8'h04;
   localparam logic [7:0] OFF_RANGE_HI = 8'h08;
   localparam logic [7:0] OFF_RATIO    = 8'h0C;
   localparam logic [7:0] OFF_BIAS     = 8'h10;
   localparam logic [7:0] OFF_FILT     = 8'h14;
   localparam logic [7:0] OFF_SP_LO    = 8'h18;
   localparam logic [7:0] OFF_SP_HI    = 8'h1C;
   localparam logic [7:0] OFF_INPUT    = 8'h20;
   localparam logic [7:0] OFF_STATUS   = 8'h24;
   localparam logic [7:0] OFF_REMOTE   = 8'h28;
   localparam logic [7:0] OFF_ACTIVE   = 8'h2C;
   localparam logic [7:0] OFF_LSP_BASE = 8'h40;
   localparam logic [7:0] OFF_PID_BASE = 8'h60;
   localparam logic [7:0] OFF_PID_RSP  = 8'h80;
   // Control field positions
   localparam int CTRL_TYPE_LSB  = 0;
   localparam int CTRL_DP_LSB    = 4;
   localparam int CTRL_REMOTE    = 8;
   localparam int CTRL_COUNT_LSB = 12;
   localparam int CTRL_DISP_LSB  = 16;
   localparam int CTRL_CONTACT   = 24;
   localparam int DISP_GROUP_BIT = 2;
   // Reset values
   localparam logic [2:0]  TYPE_RST   = 3'h0;
   localparam logic [15:0] RANGE_LO_RST = 16'h0000;
   localparam logic [15:0] RANGE_HI_RST = 16'h03E8;
   localparam logic [15:0] RATIO_RST  = 16'h03E8;
   localparam logic [15:0] BIAS_RST   = 16'h0000;
   localparam logic [10:0] FILT_RST   = 11'h000;
   localparam logic [3:0]  GROUP_RST  = 4'h1;
   // Setting bounds
   localparam logic signed [15:0] VAL_MIN  = -16'sd1999;
   localparam logic signed [15:0] VAL_MAX  = 16'sd9999;
   localparam logic [15:0] RATIO_MIN  = 16'h0001;
   localparam logic [15:0] RATIO_MAX  = 16'h270F;
   localparam logic [10:0] FILT_MAX   = 11'h4B0;
   localparam logic [15:0] RATIO_ONE  = 16'h03E8;
   // Normalized input: 0..10000 counts of 0..10 V or 0..20 mA
   localparam logic [15:0] IN_FULL = 16'h2710;
   // Sample period 0.1 s at 125 MHz
   localparam int    CLK_HZ       = 125000000;
   localparam real   SAMPLE_S     = 0.1;
   localparam int    SAMPLE_CYC   = int'(SAMPLE_S * CLK_HZ);
   localparam int    NUM_LSP      = 8;
   // Input type codes
   typedef enum logic [2:0] {
      IN_4_20MA = 3'h0, IN_0_20MA = 3'h1, IN_0_5V = 3'h2,
      IN_1_5V = 3'h3, IN_0_10V = 3'h4
   } rsc_in_type;
   typedef rsc_in_type rsc_in_type_type;
   // Alarm pair
   typedef struct packed {
      logic high;
      logic low;
   } rsc_alarm_type;
endpackage

/* File: src/rsc_divider.sv */
// Sample tick divider for the remote setpoint path
`timescale 1ns/1ps
`default_nettype none
module rsc_divider #(
   parameter int PERIOD = 12500000
) (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Tick
   output logic      tick
);
   logic [31:0] count;
   // Counts up and pulses once per period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 32'h00000000;
         tick  <= 1'b0;
      end else if (count == 32'(PERIOD - 1)) begin
         count <= 32'h00000000;
         tick  <= 1'b1;
      end else begin
         count <= count + 32'h00000001;
         tick  <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: src/rsc_top.sv */
// Remote setpoint conditioning with local setpoint store and APB registers
//
// Summary of operation
// - Input type code 0..4 selects signal range; resets to 4-20 mA.
// - Low and high scaling endpoints, -1999..9999, reset 0 and 1000.
// - Endpoint decimal point follows the process variable setting, 0..3.
// - Output equals scaled input times ratio plus bias.
// - Lag filter each 0.1 s: out += (in - out)/(T/0.1 + 1).
// - Remote setpoint clamped to -10 and +110 percent of range.
// - In remote mode pre-ratio value above/below limits raises alarms.
// - Both limit alarms are suppressed in local mode.
// - Active remote setpoint is also clamped to setpoint limits.
// - Eight local setpoints within setpoint limits, reset 0; remote read-only.
// - Only groups within configured count are readable or writable.
// - PID group numbers 1..8, reset 1, for remote and each local.
// - Remote parameters accessible only when the remote option exists.
// - Active local group 1..configured count, resets to 1.
// - Group shown only when count at least 2 and display bit 2 set.
// - Group writable only when shown and no contact selection assigned.
// - Remote value from analog input; locals held internally.
// - Setpoint writes rejected while in remote mode.
// - No ramping is ever applied to the remote setpoint.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module rsc_top
   import rsc_pkg::*;
#(
   parameter int    SAMPLE_PERIOD = SAMPLE_CYC,
   parameter logic  HAS_REMOTE    = 1'b1
) (
   // Clock and reset
   input  wire logic          pclk,
   input  wire logic          presetn,
   // APB slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic               pready,
   output logic [31:0]        prdata,
   output logic               pslverr,
   // Setpoint outputs
   output logic signed [15:0] active_setpoint,
   output logic [3:0]         active_pid_group,
   output rsc_alarm_type      alarm,
   output logic               sample_tick
);
   // Control fields
   logic [2:0]  in_type;
   logic [1:0]  dec_point;
   logic        remote_mode;
   logic [3:0]  local_group_count_setting;
   logic [7:0]  pv_sp_display_setup;
   logic        contact_assigned;

   // Remote scaling settings
   logic signed [15:0] range_lo;
   logic signed [15:0] range_hi;
   logic [15:0] remote_ratio_gain;
   logic signed [15:0] remote_bias_offset;
   logic [10:0] remote_filter_time;

   // Setpoint limits, converter word
   logic signed [15:0] sp_lo;
   logic signed [15:0] sp_hi;
   logic [15:0] raw_input;

   // Group selection, stored setpoints
   logic [3:0]  active_group;
   logic [3:0]  pid_rsp;
   logic signed [15:0] local_setpoint [NUM_LSP];
   logic [3:0]  pid_lsp [NUM_LSP];

   // Filter state, remote result
   logic signed [31:0] filt_state;
   logic signed [15:0] remote_setpoint;

   // APB decode
   wire         wr_en = psel & penable & pwrite;
   wire         rd_setup = psel & ~penable & ~pwrite;
   wire [31:0]  wd = pwdata;
   wire signed [15:0] wd16 = pwdata[15:0];
   wire [2:0]   idx = paddr[4:2];
   wire         is_lsp = (paddr[7:5] == OFF_LSP_BASE[7:5]);
   wire         is_pid = (paddr[7:5] == OFF_PID_BASE[7:5]);
   wire         idx_ok = ({1'b0, idx} < local_group_count_setting);
   wire         group_shown = (local_group_count_setting >= 4'h2) &&
                  pv_sp_display_setup[DISP_GROUP_BIT];
   wire         group_wr_ok = group_shown & ~contact_assigned;
   wire         remote_reg = (paddr == OFF_RANGE_LO) ||
                  (paddr == OFF_RANGE_HI) || (paddr == OFF_RATIO) ||
                  (paddr == OFF_BIAS) || (paddr == OFF_FILT) ||
                  (paddr == OFF_REMOTE) || (paddr == OFF_PID_RSP);
   wire         remote_ok = HAS_REMOTE | ~remote_reg;
   wire         in_val = (wd16 >= VAL_MIN) && (wd16 <= VAL_MAX);
   wire         sp_val = (wd16 >= sp_lo) && (wd16 <= sp_hi);
   wire         pid_val = (wd[3:0] >= 4'h1) && (wd[3:0] <= 4'h8);
   wire         known = (paddr <= OFF_ACTIVE && paddr[1:0] == 2'b00) ||
                  is_lsp || is_pid || paddr == OFF_PID_RSP;
   wire         bad_acc = ~known | ~remote_ok |
                  ((is_lsp | is_pid) & ~idx_ok) |
                  (pwrite & paddr == OFF_REMOTE) |
                  (pwrite & paddr == OFF_STATUS);
   // Zero wait; refused access changes nothing
   assign pready  = 1'b1;
   assign pslverr = psel & penable & bad_acc;
   wire         wr_ok = wr_en & ~bad_acc;

   // Control register write
   // Bad type or count codes keep old value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_type <= TYPE_RST;
         dec_point <= 2'h0;
         remote_mode <= 1'b0;
         local_group_count_setting <= GROUP_RST;
         pv_sp_display_setup <= 8'h00;
         contact_assigned <= 1'b0;
      end else if (wr_ok && paddr == OFF_CTRL) begin
         if (wd[CTRL_TYPE_LSB +: 3] <= 3'h4)
            in_type <= wd[CTRL_TYPE_LSB +: 3];
         dec_point <= wd[CTRL_DP_LSB +: 2];
         remote_mode <= wd[CTRL_REMOTE] & HAS_REMOTE;
         if (wd[CTRL_COUNT_LSB +: 4] >= 4'h1 &&
             wd[CTRL_COUNT_LSB +: 4] <= 4'h8)
            local_group_count_setting <= wd[CTRL_COUNT_LSB +: 4];
         pv_sp_display_setup <= wd[CTRL_DISP_LSB +: 8];
         contact_assigned <= wd[CTRL_CONTACT];
      end
   end

   // Remote parameter writes
   // Out-of-span values dropped silently
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         range_lo <= RANGE_LO_RST;
         range_hi <= RANGE_HI_RST;
         remote_ratio_gain <= RATIO_RST;
         remote_bias_offset <= BIAS_RST;
         remote_filter_time <= FILT_RST;
         pid_rsp <= GROUP_RST;
      end else if (wr_ok) begin
         if (paddr == OFF_RANGE_LO && in_val)
            range_lo <= wd16;
         if (paddr == OFF_RANGE_HI && in_val)
            range_hi <= wd16;
         if (paddr == OFF_RATIO && wd[15:0] >= RATIO_MIN &&
             wd[15:0] <= RATIO_MAX)
            remote_ratio_gain <= wd[15:0];
         if (paddr == OFF_BIAS && in_val)
            remote_bias_offset <= wd16;
         if (paddr == OFF_FILT && wd[10:0] <= FILT_MAX)
            remote_filter_time <= wd[10:0];
         if (paddr == OFF_PID_RSP && pid_val)
            pid_rsp <= wd[3:0];
      end
   end

   // Setpoint limits and analog input word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_lo <= VAL_MIN;
         sp_hi <= VAL_MAX;
         raw_input <= 16'h0000;
      end else if (wr_ok) begin
         if (paddr == OFF_SP_LO && in_val)
            sp_lo <= wd16;
         if (paddr == OFF_SP_HI && in_val)
            sp_hi <= wd16;
         if (paddr == OFF_INPUT)
            raw_input <= wd[15:0];
      end
   end

   // Active local group
   // Shrinking count pulls group down
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_group <= GROUP_RST;
      end else if (active_group > local_group_count_setting) begin
         active_group <= local_group_count_setting;
      end else if (wr_ok && paddr == OFF_ACTIVE && group_wr_ok &&
                   wd[3:0] >= 4'h1 &&
                   wd[3:0] <= local_group_count_setting) begin
         active_group <= wd[3:0];
      end
   end

   // Local setpoints and their PID groups
   // Locals frozen in remote mode
   genvar g;
   for (g = 0; g < NUM_LSP; g++) begin : g_lsp
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            local_setpoint[g] <= 16'sh0000;
            pid_lsp[g] <= GROUP_RST;
         end else if (wr_ok && idx == 3'(g)) begin
            if (is_lsp && sp_val && !remote_mode)
               local_setpoint[g] <= wd16;
            if (is_pid && pid_val)
               pid_lsp[g] <= wd[3:0];
         end
      end
   end

   // Sample tick
   rsc_divider #(
      .PERIOD (SAMPLE_PERIOD)
   ) u_div (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (sample_tick)
   );

   // Normalization of the input per type, 0..10000 counts
   // Below live zero goes negative for the low alarm
   wire signed [31:0] raw_s = 32'($signed({1'b0, raw_input}));
   logic signed [31:0] norm;
   logic signed [31:0] span_raw;
   always_comb begin
      norm = 32'sh0;
      span_raw = 32'sh0;
      unique case (in_type)
         IN_4_20MA: norm = (raw_s - 32'sd2000) * 32'sd10000
                           / 32'sd8000;
         IN_0_20MA: norm = raw_s;
         IN_0_5V:   norm = raw_s * 32'sd2;
         IN_1_5V:   norm = (raw_s - 32'sd1000) * 32'sd10000
                           / 32'sd4000;
         default:   norm = raw_s;
      endcase
      span_raw = 32'(range_hi) - 32'(range_lo);
   end

   // Scaling, ratio and bias, clamp limits
   // Limits: a tenth of span past each end
   wire signed [31:0] scaled = 32'(range_lo) + norm * span_raw
                               / 32'sd10000;
   wire signed [31:0] lim_lo = 32'(range_lo) - span_raw / 32'sd10;
   wire signed [31:0] lim_hi = 32'(range_hi) + span_raw / 32'sd10;
   wire signed [47:0] ratio_p = 48'(scaled) *
                                48'($signed({16'h0, remote_ratio_gain}));
   wire signed [31:0] ratioed = 32'(ratio_p / 48'sd1000) +
                                32'(remote_bias_offset);

   // Filter divisor T/0.1 + 1; T held in tenths of a second
   // T of zero: divisor one, no lag
   wire signed [31:0] fdiv = 32'($signed({21'h0, remote_filter_time}))
                             + 32'sd1;
   wire signed [31:0] fstep = (ratioed - filt_state) / fdiv;
   wire signed [31:0] next_filt = filt_state + fstep;

   // Lag filter state, updated once per sample
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         filt_state <= 32'sh0;
      else if (sample_tick)
         filt_state <= next_filt;
   end

   // Clamp after filter
   // Setpoint limits only on the remote path
   wire signed [31:0] clamp1 = (filt_state > lim_hi) ? lim_hi :
                               (filt_state < lim_lo) ? lim_lo :
                               filt_state;
   wire signed [31:0] clamp2 = (clamp1 > 32'(sp_hi)) ? 32'(sp_hi) :
                               (clamp1 < 32'(sp_lo)) ? 32'(sp_lo) :
                               clamp1;

   wire         alm_hi = remote_mode && (scaled > lim_hi);
   wire         alm_lo = remote_mode && (scaled < lim_lo);
   wire signed [15:0] lsp_sel = local_setpoint[3'(active_group - 4'h1)];
   // Remote path never ramps; locals go straight out here as well
   wire signed [15:0] next_active = remote_mode ? 16'(clamp2) :
                                    lsp_sel;
   wire [3:0]   next_pid = remote_mode ? pid_rsp :
                           pid_lsp[3'(active_group - 4'h1)];

   // Registered outputs
   // Alarms lag scaled input by one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         remote_setpoint <= 16'sh0;
         active_setpoint <= 16'sh0;
         active_pid_group <= GROUP_RST;
         alarm <= '0;
      end else begin
         remote_setpoint <= 16'(clamp1);
         active_setpoint <= next_active;
         active_pid_group <= next_pid;
         alarm.high <= alm_hi & HAS_REMOTE;
         alarm.low  <= alm_lo & HAS_REMOTE;
      end
   end

   // Read multiplexer
   // Signed values read zero-extended
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      if (is_lsp)
         rd_mux = 32'($unsigned(local_setpoint[idx]));
      else if (is_pid)
         rd_mux = {28'h0, pid_lsp[idx]};
      else if (paddr == OFF_PID_RSP)
         rd_mux = {28'h0, pid_rsp};
      else begin
         unique case (paddr)
            OFF_CTRL: rd_mux = {7'h0, contact_assigned,
                                pv_sp_display_setup,
                                local_group_count_setting, 3'h0,
                                remote_mode, 2'h0, dec_point, 1'b0,
                                in_type};
            OFF_RANGE_LO: rd_mux = {16'h0, range_lo};
            OFF_RANGE_HI: rd_mux = {16'h0, range_hi};
            OFF_RATIO:    rd_mux = {16'h0, remote_ratio_gain};
            OFF_BIAS:     rd_mux = {16'h0, remote_bias_offset};
            OFF_FILT:     rd_mux = {21'h0, remote_filter_time};
            OFF_SP_LO:    rd_mux = {16'h0, sp_lo};
            OFF_SP_HI:    rd_mux = {16'h0, sp_hi};
            OFF_INPUT:    rd_mux = {16'h0, raw_input};
            OFF_STATUS:   rd_mux = {29'h0, group_shown, alarm};
            OFF_REMOTE:   rd_mux = {16'h0, remote_setpoint};
            OFF_ACTIVE:   rd_mux = group_shown ? {28'h0, active_group}
                                   : 32'h0;
            default:      rd_mux = 32'h0;
         endcase
      end
   end

   // Read data register
   // Setup-cycle capture, held to next read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h0;
      else if (rd_setup)
         prdata <= rd_mux;
   end
endmodule
`default_nettype wire

/* File: bench/rsc_checker_assertions.sv */
// Port-level concurrent checks for the remote setpoint block
`timescale 1ns/1ps
`default_nettype none
module rsc_checker
   import rsc_pkg::*;
#(
   parameter int SAMPLE_PERIOD = 20
) (
   // Clock and reset
   input wire logic                pclk,
   input wire logic                presetn,
   // APB
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [7:0]          paddr,
   input wire logic [31:0]         pwdata,
   input wire logic                pready,
   input wire logic [31:0]         prdata,
   input wire logic                pslverr,
   // Setpoint outputs
   input wire logic signed [15:0]  active_setpoint,
   input wire logic [3:0]          active_pid_group,
   input wire rsc_alarm_type       alarm,
   input wire logic                sample_tick
);
   int   gap;
   logic seen;
   logic rmode;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Cycles since last tick, and the mode taken from control writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap <= 0;
         seen <= 1'b0;
         rmode <= 1'b0;
      end else begin
         gap <= sample_tick ? 0 : gap + 1;
         seen <= seen | sample_tick;
         if (psel && penable && pwrite && paddr == OFF_CTRL) begin
            rmode <= pwdata[CTRL_REMOTE];
         end
      end
   end
   chk_tick_period: assert property (sample_tick && seen |-> gap == SAMPLE_PERIOD - 1)
      else $error("sample tick spacing wrong");
   chk_tick_pulse: assert property (sample_tick |=> !sample_tick)
      else $error("sample tick longer than one cycle");
   chk_alarm_excl: assert property (!(alarm.high && alarm.low))
      else $error("both limit alarms raised");
   chk_local_quiet: assert property (!rmode && !$past(rmode) && !$past(rmode, 2) |-> alarm == 2'b00)
      else $error("limit alarm raised in local mode");
   chk_pid_range: assert property (active_pid_group inside {[1:8]})
      else $error("pid group out of range");
   chk_unmapped_err: assert property (psel && penable && paddr == 8'h30 |-> pslverr)
      else $error("unmapped access not refused");
   chk_ro_write: assert property (psel && penable && pwrite && paddr == OFF_REMOTE |-> pslverr)
      else $error("remote setpoint write not refused");
   chk_err_access: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   chk_sp_bounds: assert property (active_setpoint >= VAL_MIN && active_setpoint <= VAL_MAX)
      else $error("setpoint outside settable range");
   cov_tick: cover property (sample_tick);
   cov_high: cover property (alarm.high);
   cov_low: cover property (alarm.low);
   cov_err: cover property (pslverr);
endmodule
`default_nettype wire

/* File: bench/rsc_source_model.sv */
// Analog remote setpoint source: signal level to converter counts
`timescale 1ns/1ps
`default_nettype none
module rsc_source_model
   import rsc_pkg::*;
(
   // Signal selection, level in per mille of the signal span
   input wire rsc_in_type_type     sig_type,
   input wire logic signed [15:0]  level_pm,
   // Converter counts
   output logic [15:0]             raw
);
   int lo;
   int hi;
   int v;
   // Span ends per signal type; the converter saturates at its limits
   assign lo = (sig_type == IN_4_20MA) ? 2000 : (sig_type == IN_1_5V) ? 1000 : 0;
   assign hi = (sig_type == IN_0_5V || sig_type == IN_1_5V) ? 5000 : 10000;
   assign v = lo + (hi - lo) * level_pm / 1000;
   assign raw = v < 0 ? 16'h0000 : v > 10000 ? IN_FULL : v[15:0];
endmodule
`default_nettype wire

/* File: bench/rsc_tb_top.sv */
// Self-checking bench for the remote setpoint block
`timescale 1ns/1ps
`default_nettype none
module rsc_tb_top;
   import rsc_pkg::*;
   localparam int SP = 20;
   logic               pclk, presetn, psel, penable, pwrite;
   logic               pready, pslverr, sample_tick;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata, v;
   logic signed [15:0] active_setpoint, src_pm;
   logic [3:0]         active_pid_group;
   logic [15:0]        src_raw;
   rsc_alarm_type      alarm;
   rsc_in_type_type    src_type;
   int                 n_mismatch, compares;
   rsc_top #(.SAMPLE_PERIOD(SP), .HAS_REMOTE(1'b1)) rsc_top_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .active_setpoint(active_setpoint),
      .active_pid_group(active_pid_group), .alarm(alarm),
      .sample_tick(sample_tick));
   rsc_source_model rsc_source_model_i (
      .sig_type(src_type), .level_pm(src_pm), .raw(src_raw));
   // Clock
   always #4 pclk = ~pclk;
   task automatic cmp_word(input string nm, input logic [31:0] x, g);
      compares++;
      if (g !== x) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic cmp_bit(input string nm, input logic x, g);
      compares++;
      if (g !== x) begin
         n_mismatch++;
         $display("MISMATCH %s expected %b seen %b", nm, x, g);
      end
   endtask
   // One APB transfer; read data lands in v, error flag is judged
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic ee);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk);
      while (pready !== 1'b1);
      v = prdata;
      cmp_bit("pslverr", ee, pslverr);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdx(input string nm, input logic [7:0] a,
                      input logic [31:0] x);
      apb(1'b0, a, 32'h0, 1'b0);
      cmp_word(nm, x, v);
   endtask
   function automatic logic [31:0] ctrl(input logic [2:0] t,
      input logic [1:0] dp, input logic rem, input logic [3:0] cnt,
      input logic [7:0] disp, input logic con);
      return {7'h00, con, disp, cnt, 3'h0, rem, 2'h0, dp, 1'b0, t};
   endfunction
   task automatic ticks(input int n);
      repeat (n * SP + 2) @(posedge pclk);
   endtask
   // Source level to the input register
   task automatic feed(input rsc_in_type_type t, input logic signed [15:0] pm);
      src_type <= t;
      src_pm <= pm;
      @(posedge pclk);
      apb(1'b1, OFF_INPUT, {16'h0000, src_raw}, 1'b0);
   endtask
   task automatic t_reset();
      logic [7:0] a [9] = '{OFF_RANGE_LO, OFF_RANGE_HI, OFF_RATIO, OFF_BIAS,
         OFF_FILT, OFF_LSP_BASE, OFF_PID_BASE, OFF_PID_RSP, OFF_ACTIVE};
      logic [15:0] x [9] = '{RANGE_LO_RST, RANGE_HI_RST, RATIO_RST, BIAS_RST,
         {5'h00, FILT_RST}, 16'h0000, 16'h0001, 16'h0001, 16'h0000};
      for (int i = 0; i < 9; i++) begin
         rdx("reset value", a[i], {16'h0000, x[i]});
      end
      apb(1'b0, OFF_CTRL, 32'h0, 1'b0);
      cmp_word("type", 32'(TYPE_RST), {29'h0, v[2:0]});
      cmp_word("pid out", 32'h1, {28'h0, active_pid_group});
   endtask
   task automatic t_errors();
      apb(1'b1, OFF_REMOTE, 32'h5, 1'b1);
      apb(1'b1, OFF_STATUS, 32'h1, 1'b1);
      apb(1'b0, 8'h30, 32'h0, 1'b1);
      apb(1'b0, OFF_LSP_BASE + 8'h04, 32'h0, 1'b1);
   endtask
   // Every type at half span: ratio 2.000, bias 10, endpoints 0..1000
   task automatic t_scale();
      apb(1'b1, OFF_SP_LO, 32'h0000F831, 1'b0);
      apb(1'b1, OFF_SP_HI, 32'h0000270F, 1'b0);
      apb(1'b1, OFF_RATIO, 32'h000007D0, 1'b0);
      apb(1'b1, OFF_BIAS, 32'h0000000A, 1'b0);
      for (int t = 0; t < 5; t++) begin
         apb(1'b1, OFF_CTRL, ctrl(t[2:0], t[1:0], 1'b1, 4'h1, 8'h00, 1'b0), 1'b0);
         rdx("ctrl", OFF_CTRL,
             ctrl(t[2:0], t[1:0], 1'b1, 4'h1, 8'h00, 1'b0));
         feed(rsc_in_type_type'(t[2:0]), 16'sd500);
         ticks(2);
         rdx("remote", OFF_REMOTE, 32'h3F2);
         cmp_word("active", 32'h3F2, {16'h0, active_setpoint});
      end
   endtask
   task automatic t_alarm();
      apb(1'b1, OFF_RATIO, 32'h3E8, 1'b0);
      apb(1'b1, OFF_BIAS, 32'h0, 1'b0);
      apb(1'b1, OFF_CTRL, ctrl(3'h0, 2'h0, 1'b1, 4'h1, 8'h00, 1'b0), 1'b0);
      feed(IN_4_20MA, -16'sd250);
      ticks(2);
      cmp_word("alarm", 32'h1, {30'h0, alarm});
      rdx("clamp low", OFF_REMOTE, 32'hFF9C);
      apb(1'b1, OFF_CTRL, ctrl(3'h3, 2'h0, 1'b1, 4'h1, 8'h00, 1'b0), 1'b0);
      feed(IN_1_5V, 16'sd2250);
      ticks(2);
      cmp_word("alarm", 32'h2, {30'h0, alarm});
      rdx("clamp high", OFF_REMOTE, 32'h44C);
      apb(1'b0, OFF_STATUS, 32'h0, 1'b0);
      cmp_word("status", 32'h2, {29'h0, v[2:0]});
      apb(1'b1, OFF_CTRL, ctrl(3'h3, 2'h0, 1'b0, 4'h1, 8'h00, 1'b0), 1'b0);
      ticks(1);
      cmp_word("alarm", 32'h0, {30'h0, alarm});
      cmp_word("local sp", 32'h0, {16'h0, active_setpoint});
   endtask
   // Step from 0 to 1000 through a 1.0 s lag, then filter off
   task automatic t_filter();
      apb(1'b1, OFF_CTRL, ctrl(3'h4, 2'h0, 1'b1, 4'h1, 8'h00, 1'b0), 1'b0);
      feed(IN_0_10V, 16'sd0);
      ticks(2);
      apb(1'b1, OFF_FILT, 32'hA, 1'b0);
      feed(IN_0_10V, 16'sd1000);
      ticks(2);
      apb(1'b0, OFF_REMOTE, 32'h0, 1'b0);
      cmp_bit("lag", 1'b1, v >= 90 && v < 1000);
      apb(1'b1, OFF_FILT, 32'h0, 1'b0);
      ticks(2);
      rdx("no lag", OFF_REMOTE, 32'h3E8);
   endtask
   task automatic t_groups();
      apb(1'b1, OFF_CTRL, ctrl(3'h0, 2'h0, 1'b0, 4'h3, 8'h04, 1'b0), 1'b0);
      rdx("group", OFF_ACTIVE, 32'h1);
      apb(1'b1, OFF_LSP_BASE + 8'h04, 32'h7B, 1'b0);
      rdx("lsp1", OFF_LSP_BASE + 8'h04, 32'h7B);
      apb(1'b1, OFF_LSP_BASE + 8'h0C, 32'h5, 1'b1);
      apb(1'b1, OFF_LSP_BASE, 32'h4E20, 1'b0);
      rdx("lsp0", OFF_LSP_BASE, 32'h0);
      apb(1'b1, OFF_PID_BASE + 8'h04, 32'h9, 1'b0);
      rdx("pid1", OFF_PID_BASE + 8'h04, 32'h1);
      apb(1'b1, OFF_PID_BASE + 8'h04, 32'h8, 1'b0);
      rdx("pid1", OFF_PID_BASE + 8'h04, 32'h8);
      apb(1'b1, OFF_ACTIVE, 32'h2, 1'b0);
      rdx("group", OFF_ACTIVE, 32'h2);
      apb(1'b0, OFF_STATUS, 32'h0, 1'b0);
      cmp_bit("shown", 1'b1, v[2]);
      ticks(1);
      cmp_word("local sp", 32'h7B, {16'h0, active_setpoint});
      cmp_word("pid out", 32'h8, {28'h0, active_pid_group});
      apb(1'b1, OFF_ACTIVE, 32'h4, 1'b0);
      rdx("group", OFF_ACTIVE, 32'h2);
      apb(1'b1, OFF_CTRL, ctrl(3'h0, 2'h0, 1'b0, 4'h3, 8'h04, 1'b1), 1'b0);
      apb(1'b1, OFF_ACTIVE, 32'h3, 1'b0);
      rdx("group", OFF_ACTIVE, 32'h2);
      apb(1'b1, OFF_CTRL, ctrl(3'h0, 2'h0, 1'b0, 4'h3, 8'h00, 1'b0), 1'b0);
      apb(1'b0, OFF_STATUS, 32'h0, 1'b0);
      cmp_bit("shown", 1'b0, v[2]);
      apb(1'b1, OFF_ACTIVE, 32'h3, 1'b0);
      rdx("group", OFF_ACTIVE, 32'h0);
      cmp_word("pid out", 32'h8, {28'h0, active_pid_group});
      apb(1'b1, OFF_CTRL, ctrl(3'h0, 2'h0, 1'b1, 4'h3, 8'h04, 1'b0), 1'b0);
      apb(1'b1, OFF_LSP_BASE + 8'h04, 32'h37, 1'b0);
      rdx("lsp1", OFF_LSP_BASE + 8'h04, 32'h7B);
   endtask
   task automatic end_sim();
      $display("Mismatches %0d, compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      end_sim();
   end
   // Main sequence
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      src_type = IN_4_20MA;
      src_pm = 16'sd0;
      n_mismatch = 0;
      compares = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_errors();
      t_scale();
      t_alarm();
      t_filter();
      t_groups();
      end_sim();
   end
endmodule
bind rsc_top rsc_checker #(.SAMPLE_PERIOD(SAMPLE_PERIOD)) rsc_checker_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .active_setpoint(active_setpoint),
   .active_pid_group(active_pid_group), .alarm(alarm),
   .sample_tick(sample_tick));
`default_nettype wire
